// [lcas_config_status.sv]
// What this block does
// - Every refresh copies active control into snapshot
// - Control snapshot valid 125 us after refresh
// - Range snapshot valid one conversion after refresh
// - Mode change waits for running conversion end, except on manual refresh
// - Continuous to single-shot adds one conversion
// - Codes 0 to 5 pick continuous rates
// - Codes 6 to 9 pick single-shot variants
// - Codes a, b sample one input fast
// - Codes c, d trigger on pin edges
// - Codes e, f put converter to sleep
// - Pin function fields select pin role
// - Slow pin high forces 8 sps, top priority
// - Averaging field selects rolling average depth
// - Adaptive accumulation adjusts accumulator while slow
// - Accumulator source field selects summed quantity
// - Auto-refresh after each conversion or average
// - Auto-refresh ignores manual refresh and changes other than switching it off
// - Auto-refresh field selects clearing behaviour
// - Sense range field selects sense span
// - Bus range field selects bus span
// - Alert bit clears after read and conversion
// - Alert recorded only when enabled
`timescale 1ns/1ps
`include "lcas_defs.svh"
module lcas_config_status #(
  parameter int CTRL_VALID_CYC = (`LCAS_CTRL_VALID_PS + `LCAS_CLK_PS - 1) / `LCAS_CLK_PS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire lcas_pkg::lcas_word_type reg_wdata,
  input wire logic reg_rd,
  output lcas_pkg::lcas_word_type reg_rdata,
  input wire logic refresh_req,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire lcas_pkg::lcas_word_type alert_cond,
  input wire lcas_pkg::lcas_word_type alert_enable,
  input wire logic addr_pin_zero,
  input wire logic addr_pin_one,
  output logic refresh_pulse,
  output logic acc_clear,
  output logic extra_conv,
  output logic pin_trigger,
  output logic [14:0] sample_rate_sps,
  output logic single_shot,
  output logic shot_average,
  output logic shot_awake,
  output logic bus_only,
  output logic sense_only,
  output logic sleep_mode,
  output logic [1:0] pin_zero_function_select,
  output logic [1:0] pin_one_function_select,
  output logic [7:0] avg_depth,
  output logic adaptive_adjust,
  output logic [1:0] accumulator_input_select,
  output logic sense_bipolar,
  output logic sense_half,
  output logic bus_bipolar,
  output logic bus_half,
  output logic ctrl_snap_valid,
  output logic range_snap_valid
);
  import lcas_pkg::*;

  lcas_word_type ctrl_pend_r, ctrl_act_r, control_snapshot_r;
  lcas_range_type rng_pend_r, range_config_active_r, range_config_snapshot_r;
  lcas_word_type alert_r, rd_seen_r, rdata_r;
  lcas_snap_state_type snap_r, snap_nxt;
  logic [31:0] valid_cnt_r;
  logic rng_valid_r, refresh_r, acc_clear_r, extra_r, trig_r;
  logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r, pin_prev_r;
  logic [7:0] avg_cnt_r;

  wire [3:0] mode_act = ctrl_act_r[`LCAS_F_MODE];
  wire [3:0] mode_pend = ctrl_pend_r[`LCAS_F_MODE];
  wire [1:0] auto_fld = ctrl_act_r[`LCAS_F_AUTO];
  wire auto_on = auto_fld != `LCAS_AUTO_OFF;
  wire [1:0] pin_raw = {addr_pin_one, addr_pin_zero};

  // A pin level counts only once the last two stages agree.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
      pin_lvl_r <= 2'h0;
      pin_prev_r <= 2'h0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_lvl_r <= (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_lvl_r;
      pin_prev_r <= pin_lvl_r;
    end
  end

  wire pin0_slow = ctrl_act_r[`LCAS_F_PIN0] == `LCAS_PIN_SLOW;
  wire pin1_slow = ctrl_act_r[`LCAS_F_PIN1] == `LCAS_PIN_SLOW;
  wire slow_active = (pin0_slow && pin_lvl_r[0]) || (pin1_slow && pin_lvl_r[1]);
  wire [1:0] pin_edge = pin_lvl_r ^ pin_prev_r;

  wire is_cont = mode_act <= `LCAS_M_8;
  wire is_ss = mode_act >= `LCAS_M_SS && mode_act <= `LCAS_M_SS_AWK_AVG;
  wire is_trig = mode_act == `LCAS_M_PIN0_TRIG || mode_act == `LCAS_M_PIN1_TRIG;
  wire is_avg = mode_act == `LCAS_M_SS_AVG || mode_act == `LCAS_M_SS_AWK_AVG;
  wire pend_ss = (mode_pend >= `LCAS_M_SS && mode_pend <= `LCAS_M_SS_AWK_AVG)
    || mode_pend == `LCAS_M_PIN0_TRIG || mode_pend == `LCAS_M_PIN1_TRIG;

  // Outside a manual refresh, a pending mode is only taken up between conversions.
  wire mode_apply = (mode_pend != mode_act) && !auto_on && !conv_busy;
  wire avg_full = avg_cnt_r >= avg_depth - 8'h01;
  wire auto_fire = auto_on && conv_done && (!is_avg || avg_full);
  wire manual_fire = refresh_req && !auto_on;
  wire do_refresh = auto_fire || manual_fire;
  // Turning auto-refresh off is honoured at once, since nothing else could ever end it.
  wire auto_off_req = auto_on && ctrl_pend_r[`LCAS_F_AUTO] == `LCAS_AUTO_OFF;
  wire do_apply = manual_fire || mode_apply || auto_off_req;

  wire sel_ctrl_pend = reg_addr == `LCAS_OFS_CTRL_PEND;
  wire sel_rng_pend = reg_addr == `LCAS_OFS_RNG_PEND;
  wire sel_ctrl_snap = reg_addr == `LCAS_OFS_CTRL_SNAP;
  wire sel_rng_snap = reg_addr == `LCAS_OFS_RNG_SNAP;
  wire sel_alert = reg_addr == `LCAS_OFS_ALERT;

  // Pending words take host writes; snapshots have no write path.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_pend_r <= `LCAS_CTRL_RST;
      rng_pend_r <= `LCAS_RNG_RST;
    end else if (reg_wr) begin
      if (sel_ctrl_pend)
        ctrl_pend_r <= reg_wdata;
      if (sel_rng_pend)
        rng_pend_r <= reg_wdata[3:0];
    end
  end

  wire [3:0] mode_nxt = auto_on ? mode_act : mode_pend;
  wire [1:0] auto_nxt = auto_off_req ? `LCAS_AUTO_OFF : auto_fld;
  wire [15:0] ctrl_mode_only = {mode_nxt, ctrl_act_r[`LCAS_F_KEEP], auto_nxt};
  wire [15:0] ctrl_act_nxt = manual_fire ? ctrl_pend_r : ctrl_mode_only;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_act_r <= `LCAS_CTRL_RST;
      range_config_active_r <= `LCAS_RNG_RST;
      control_snapshot_r <= `LCAS_CTRL_SNAP_RST;
      range_config_snapshot_r <= `LCAS_RNG_RST;
    end else begin
      if (do_refresh) begin
        control_snapshot_r <= ctrl_act_r;
        range_config_snapshot_r <= range_config_active_r;
      end
      if (do_apply)
        ctrl_act_r <= ctrl_act_nxt;
      if (manual_fire)
        range_config_active_r <= rng_pend_r;
    end
  end

  // Leaving a continuous rate for a single shot costs one conversion.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      extra_r <= 1'b0;
      refresh_r <= 1'b0;
      acc_clear_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      extra_r <= (manual_fire || mode_apply) && is_cont && pend_ss
        && (mode_pend != mode_act);
      refresh_r <= do_refresh;
      acc_clear_r <= manual_fire || (auto_fire && auto_fld == `LCAS_AUTO_CLR);
      trig_r <= !slow_active && ((mode_act == `LCAS_M_PIN0_TRIG && pin_edge[0])
        || (mode_act == `LCAS_M_PIN1_TRIG && pin_edge[1]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      avg_cnt_r <= 8'h00;
    else if (do_refresh)
      avg_cnt_r <= 8'h00;
    else if (conv_done && is_avg)
      avg_cnt_r <= avg_cnt_r + 8'h01;
  end

  // Control snapshot validity waits out the result settling time.
  always_comb begin
    case (snap_r)
      LCAS_SNAP_VALID: snap_nxt = do_refresh ? LCAS_SNAP_WAIT : LCAS_SNAP_VALID;
      LCAS_SNAP_WAIT: begin
        if (do_refresh)
          snap_nxt = LCAS_SNAP_WAIT;
        else if (valid_cnt_r >= 32'(CTRL_VALID_CYC - 1))
          snap_nxt = LCAS_SNAP_VALID;
        else
          snap_nxt = LCAS_SNAP_WAIT;
      end
      default: snap_nxt = LCAS_SNAP_VALID;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snap_r <= LCAS_SNAP_VALID;
      valid_cnt_r <= 32'h0;
      rng_valid_r <= 1'b1;
    end else begin
      snap_r <= snap_nxt;
      valid_cnt_r <= (snap_nxt == LCAS_SNAP_WAIT && !do_refresh) ? valid_cnt_r + 32'h1 : 32'h0;
      if (do_refresh)
        rng_valid_r <= 1'b0;
      else if (conv_done)
        rng_valid_r <= 1'b1;
    end
  end

  // A read arms clearing; the next completed conversion clears unless the cause persists.
  wire [15:0] alert_new = alert_cond & alert_enable & `LCAS_ALERT_MASK;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alert_r <= 16'h0000;
      rd_seen_r <= 16'h0000;
    end else begin
      if (conv_done)
        alert_r <= (alert_r & ~rd_seen_r) | alert_new;
      if (conv_done)
        rd_seen_r <= 16'h0000;
      else if (reg_rd && sel_alert)
        rd_seen_r <= rd_seen_r | alert_r;
    end
  end

  wire [15:0] rd_mux = sel_ctrl_pend ? ctrl_pend_r
    : sel_rng_pend ? {12'h000, rng_pend_r}
    : sel_ctrl_snap ? control_snapshot_r
    : sel_rng_snap ? {12'h000, range_config_snapshot_r}
    : sel_alert ? alert_r : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (rst)
      rdata_r <= 16'h0000;
    else if (reg_rd)
      rdata_r <= rd_mux;
  end

  // Rate decode; a high slow pin overrides every programmed mode.
  logic [14:0] rate_w;
  always_comb begin
    case (mode_act)
      `LCAS_M_8192: rate_w = 15'd8192;
      `LCAS_M_4096: rate_w = 15'd4096;
      `LCAS_M_1024: rate_w = 15'd1024;
      `LCAS_M_256: rate_w = 15'd256;
      `LCAS_M_64: rate_w = 15'd64;
      `LCAS_M_8: rate_w = `LCAS_SPS_SLOW;
      `LCAS_M_BUS_ONLY, `LCAS_M_SNS_ONLY: rate_w = `LCAS_SPS_FAST;
      default: rate_w = 15'd0;
    endcase
  end

  logic [7:0] depth_w;
  always_comb begin
    case (ctrl_act_r[`LCAS_F_AVG])
      3'h0: depth_w = 8'd4;
      3'h1: depth_w = 8'd8;
      3'h2: depth_w = 8'd16;
      3'h3: depth_w = 8'd32;
      3'h5: depth_w = 8'd64;
      3'h7: depth_w = 8'd128;
      default: depth_w = 8'd8;
    endcase
  end

  wire [1:0] vs_w = range_config_active_r[`LCAS_F_VS];
  wire [1:0] vb_w = range_config_active_r[`LCAS_F_VB];

  assign reg_rdata = rdata_r;
  assign refresh_pulse = refresh_r;
  assign acc_clear = acc_clear_r;
  assign extra_conv = extra_r;
  assign pin_trigger = trig_r;
  assign sample_rate_sps = slow_active ? `LCAS_SPS_SLOW : rate_w;
  assign single_shot = !slow_active && (is_ss || is_trig);
  assign shot_average = is_avg;
  assign shot_awake = mode_act == `LCAS_M_SS_AWK || mode_act == `LCAS_M_SS_AWK_AVG || is_trig;
  assign bus_only = !slow_active && mode_act == `LCAS_M_BUS_ONLY;
  assign sense_only = !slow_active && mode_act == `LCAS_M_SNS_ONLY;
  assign sleep_mode = !slow_active && mode_act >= `LCAS_M_SLEEP;
  assign pin_zero_function_select = ctrl_act_r[`LCAS_F_PIN0];
  assign pin_one_function_select = ctrl_act_r[`LCAS_F_PIN1];
  assign avg_depth = depth_w;
  assign adaptive_adjust = ctrl_act_r[`LCAS_F_AA] && slow_active;
  assign accumulator_input_select = ctrl_act_r[`LCAS_F_ACC];
  assign sense_bipolar = vs_w == `LCAS_RNG_BI || vs_w == `LCAS_RNG_HALF;
  assign sense_half = vs_w == `LCAS_RNG_HALF;
  assign bus_bipolar = vb_w == `LCAS_RNG_BI || vb_w == `LCAS_RNG_HALF;
  assign bus_half = vb_w == `LCAS_RNG_HALF;
  assign ctrl_snap_valid = snap_r == LCAS_SNAP_VALID;
  assign range_snap_valid = rng_valid_r;

  sequence refresh_s;
    do_refresh;
  endsequence
  sequence settle_s;
    !ctrl_snap_valid [*8];
  endsequence

  snap_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
    do_refresh |=> control_snapshot_r == $past(ctrl_act_r))
    else $error("control snapshot missed active copy");
  snap_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
    refresh_s |=> settle_s) else $error("control snapshot valid too early");
  range_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    (do_refresh && !conv_done) |=> !range_snap_valid)
    else $error("range snapshot valid before conversion");
  mode_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (conv_busy && !manual_fire) |=> $stable(ctrl_act_r[15:12]))
    else $error("mode changed during conversion");
  manual_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    (auto_on && refresh_req && !conv_done) |=> !refresh_pulse)
    else $error("manual refresh taken under auto refresh");
  auto_fire_a: assert property (@(posedge clk_sys) disable iff (rst)
    (auto_on && conv_done && !is_avg) |=> refresh_pulse)
    else $error("auto refresh missing after conversion");
  slow_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
    slow_active |-> sample_rate_sps == `LCAS_SPS_SLOW && !pin_trigger)
    else $error("slow pin did not force slow rate");
  alert_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (alert_r & ~$past(alert_r) & ~$past(alert_enable)) == 16'h0000)
    else $error("alert set without enable");
  alert_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!conv_done && alert_r != 16'h0000) |=> (alert_r & $past(alert_r)) == $past(alert_r))
    else $error("alert cleared without conversion");
  snap_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_ctrl_snap && !do_refresh) |=> $stable(control_snapshot_r))
    else $error("snapshot took a host write");
  auto_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    auto_off_req |=> !auto_on)
    else $error("auto refresh could not be disabled");
endmodule // lcas_config_status

// [lcas_defs.svh]
`ifndef LCAS_DEFS_SVH
`define LCAS_DEFS_SVH
// Register offsets.
`define LCAS_OFS_CTRL_PEND 8'h01
`define LCAS_OFS_RNG_PEND 8'h1d
`define LCAS_OFS_CTRL_SNAP 8'h0f
`define LCAS_OFS_RNG_SNAP 8'h10
`define LCAS_OFS_ALERT 8'h11
// Reset values.
`define LCAS_CTRL_RST 16'h2520
`define LCAS_CTRL_SNAP_RST 16'h2500
`define LCAS_RNG_RST 4'h0
// Control and range word fields.
`define LCAS_F_MODE 15:12
`define LCAS_F_PIN1 11:10
`define LCAS_F_PIN0 9:8
`define LCAS_F_AVG 7:5
`define LCAS_F_AA 4
`define LCAS_F_ACC 3:2
`define LCAS_F_AUTO 1:0
`define LCAS_F_VS 3:2
`define LCAS_F_VB 1:0
`define LCAS_F_KEEP 11:2
// Alert status bits that exist.
`define LCAS_ALERT_MASK 16'h3ffc
// Sample mode codes.
`define LCAS_M_8192 4'h0
`define LCAS_M_4096 4'h1
`define LCAS_M_1024 4'h2
`define LCAS_M_256 4'h3
`define LCAS_M_64 4'h4
`define LCAS_M_8 4'h5
`define LCAS_M_SS 4'h6
`define LCAS_M_SS_AVG 4'h7
`define LCAS_M_SS_AWK 4'h8
`define LCAS_M_SS_AWK_AVG 4'h9
`define LCAS_M_BUS_ONLY 4'ha
`define LCAS_M_SNS_ONLY 4'hb
`define LCAS_M_PIN0_TRIG 4'hc
`define LCAS_M_PIN1_TRIG 4'hd
`define LCAS_M_SLEEP 4'he
// Pin functions, auto-refresh and range codes.
`define LCAS_PIN_ALERT 2'h0
`define LCAS_PIN_GPI 2'h1
`define LCAS_PIN_GPO 2'h2
`define LCAS_PIN_SLOW 2'h3
`define LCAS_AUTO_OFF 2'h0
`define LCAS_AUTO_CLR 2'h1
`define LCAS_AUTO_KEEP 2'h2
`define LCAS_RNG_UNI 2'h0
`define LCAS_RNG_BI 2'h1
`define LCAS_RNG_HALF 2'h2
// Rates in samples per second.
`define LCAS_SPS_FAST 15'h4000
`define LCAS_SPS_SLOW 15'h0008
// Timing.
`define LCAS_CLK_PS 8000
`define LCAS_CTRL_VALID_PS 125000000
`endif

// [lcas_host_model.sv]
`timescale 1ns/1ps
module lcas_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output lcas_pkg::lcas_word_type reg_wdata,
  output logic reg_rd,
  output logic refresh_req,
  input wire lcas_pkg::lcas_word_type reg_rdata
);
  import lcas_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    refresh_req = 1'b0;
  end
  // Released address and data are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input lcas_word_type v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output lcas_word_type v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rdata;
  endtask
  task automatic refresh();
    @(posedge clk_sys);
    refresh_req <= 1'b1;
    @(posedge clk_sys);
    refresh_req <= 1'b0;
  endtask
endmodule // lcas_host_model

// [lcas_pkg.sv]
package lcas_pkg;
  typedef logic [15:0] lcas_word_type;
  typedef logic [3:0] lcas_range_type;
  typedef enum logic [1:0] {
    LCAS_SNAP_VALID = 2'b01,
    LCAS_SNAP_WAIT = 2'b10
  } lcas_snap_state_type;
endpackage

// [test_latched_config_and_alert_status.sv]
`timescale 1ns/1ps
module test_latched_config_and_alert_status;
  import lcas_pkg::*;
  logic clk_sys, rst, conv_busy, conv_done, addr_pin_zero, addr_pin_one, reg_wr, reg_rd;
  logic refresh_req, refresh_pulse, acc_clear, extra_conv, pin_trigger, single_shot;
  logic shot_average, shot_awake, bus_only, sense_only, sleep_mode, adaptive_adjust;
  logic sense_bipolar, sense_half, bus_bipolar, bus_half, ctrl_snap_valid, range_snap_valid;
  logic [7:0] reg_addr, avg_depth;
  logic [14:0] sample_rate_sps;
  logic [1:0] pin_zero_function_select, pin_one_function_select, accumulator_input_select;
  lcas_word_type reg_wdata, reg_rdata, alert_cond, alert_enable, d, prv;
  int error_cnt = 0;
  int compares = 0;
  int n_ref, n_clr, n_xc, n_trig;
  logic [14:0] rt [16] = '{15'h2000, 15'h1000, 15'h0400, 15'h0100, 15'h0040, 15'h0008,
    15'h0, 15'h0, 15'h0, 15'h0, 15'h4000, 15'h4000, 15'h0, 15'h0, 15'h0, 15'h0};
  logic [7:0] dp [8] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h08, 8'h40, 8'h08, 8'h80};
  lcas_config_status #(.CTRL_VALID_CYC(20)) u_dut (
    .clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .refresh_req,
    .conv_busy, .conv_done, .alert_cond, .alert_enable, .addr_pin_zero, .addr_pin_one,
    .refresh_pulse, .acc_clear, .extra_conv, .pin_trigger, .sample_rate_sps, .single_shot,
    .shot_average, .shot_awake, .bus_only, .sense_only, .sleep_mode,
    .pin_zero_function_select, .pin_one_function_select, .avg_depth, .adaptive_adjust,
    .accumulator_input_select, .sense_bipolar, .sense_half, .bus_bipolar, .bus_half,
    .ctrl_snap_valid, .range_snap_valid
  );
  lcas_host_model u_host (
    .clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .refresh_req, .reg_rdata
  );
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulse outputs are counted so a test can judge them without racing their one cycle.
  always @(posedge clk_sys) begin
    n_ref += (refresh_pulse === 1'b1);
    n_clr += (acc_clear === 1'b1);
    n_xc += (extra_conv === 1'b1);
    n_trig += (pin_trigger === 1'b1);
  end
  task automatic chk(input lcas_word_type got, input lcas_word_type exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic zc();
    n_ref = 0;
    n_clr = 0;
    n_xc = 0;
    n_trig = 0;
  endtask
  task automatic cv();
    @(posedge clk_sys) conv_done <= 1'b1;
    @(posedge clk_sys) conv_done <= 1'b0;
  endtask
  task automatic rs();
    @(posedge clk_sys) rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    alert_cond = 16'h0000;
    alert_enable = 16'h0000;
    addr_pin_zero = 1'b0;
    addr_pin_one = 1'b0;
    zc();
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) u_host.wr(8'h0f + i[7:0], 16'hffff);
    u_host.rd(8'h01, d);
    chk(d, 16'h2520);
    u_host.rd(8'h0f, d);
    chk(d, 16'h2500);
    u_host.rd(8'h10, d);
    chk(d, 16'h0000);
    u_host.rd(8'h11, d);
    chk(d, 16'h0000);
    u_host.rd(8'h55, d);
    chk(d, 16'h0000);
    chk(sample_rate_sps, 15'h0400);
    chk(avg_depth, 8'h08);
    chk({pin_one_function_select, pin_zero_function_select}, 4'h5);
    $display("test reset_and_readonly done");
    u_host.wr(8'h01, 16'h28f8);
    u_host.wr(8'h1d, 16'h0006);
    zc();
    u_host.refresh();
    #1 chk(ctrl_snap_valid, 1'b0);
    chk(range_snap_valid, 1'b0);
    tk(18);
    chk(ctrl_snap_valid, 1'b0);
    tk(2);
    chk(ctrl_snap_valid, 1'b1);
    u_host.rd(8'h0f, d);
    chk(d, 16'h2520);
    u_host.rd(8'h10, d);
    chk(d, 16'h0000);
    chk(n_ref, 1);
    chk(avg_depth, 8'h80);
    chk({pin_one_function_select, pin_zero_function_select}, 4'h8);
    chk(accumulator_input_select, 2'h2);
    chk(adaptive_adjust, 1'b0);
    chk(range_snap_valid, 1'b0);
    cv();
    tk(1);
    chk(range_snap_valid, 1'b1);
    chk({sense_bipolar, sense_half, bus_half}, 3'b101);
    $display("test refresh_capture done");
    zc();
    for (int m = 0; m < 16; m++) begin
      u_host.wr(8'h01, {m[3:0], 12'h8f8});
      tk(3);
      chk(sample_rate_sps, rt[m]);
      chk(sleep_mode, m > 13);
      chk({bus_only, sense_only}, {m == 10, m == 11});
      if (m < 12) chk({single_shot, shot_average, shot_awake},
        {m > 5 && m < 10, m == 7 || m == 9, m == 8 || m == 9});
      if (m == 6) chk(n_xc, 1);
    end
    for (int a = 0; a < 8; a++) begin
      u_host.wr(8'h01, {4'h2, 4'h5, a[2:0], 5'h00});
      u_host.refresh();
      tk(1);
      chk(avg_depth, dp[a]);
    end
    prv = 16'h0006;
    for (int r = 0; r < 3; r++) begin
      u_host.wr(8'h1d, {12'h000, r[1:0], r[1:0]});
      u_host.refresh();
      tk(1);
      chk({sense_half, bus_half}, {2{r == 2}});
      if (r < 2) chk(sense_bipolar, r == 1);
      chk(bus_bipolar, r > 0);
      u_host.rd(8'h10, d);
      chk(d, prv);
      prv = {12'h000, r[1:0], r[1:0]};
    end
    $display("test field_decode done");
    u_host.wr(8'h01, 16'h2730);
    u_host.refresh();
    @(posedge clk_sys) addr_pin_zero <= 1'b1;
    tk(8);
    chk(sample_rate_sps, 15'h0008);
    chk(adaptive_adjust, 1'b1);
    @(posedge clk_sys) addr_pin_zero <= 1'b0;
    tk(8);
    chk(sample_rate_sps, 15'h0400);
    chk(adaptive_adjust, 1'b0);
    u_host.wr(8'h01, 16'h2530);
    u_host.refresh();
    for (int p = 0; p < 2; p++) begin
      u_host.wr(8'h01, {3'b110, p[0], 12'h530});
      tk(3);
      n_trig = 0;
      @(posedge clk_sys) {addr_pin_one, addr_pin_zero} <= 2'b01 << p;
      tk(8);
      chk(n_trig, 1);
      @(posedge clk_sys) {addr_pin_one, addr_pin_zero} <= 2'b00;
      tk(8);
    end
    @(posedge clk_sys) conv_busy <= 1'b1;
    u_host.wr(8'h01, 16'h2530);
    tk(3);
    chk(sample_rate_sps, 15'h0000);
    @(posedge clk_sys) conv_busy <= 1'b0;
    tk(3);
    chk(sample_rate_sps, 15'h0400);
    $display("test pins_and_modes done");
    rs();
    u_host.wr(8'h01, 16'h7501);
    u_host.refresh();
    tk(3);
    zc();
    u_host.refresh();
    tk(3);
    chk(n_ref, 0);
    u_host.wr(8'h01, 16'h2502);
    repeat (3) cv();
    tk(2);
    chk(n_ref, 0);
    cv();
    tk(2);
    chk(n_ref, 1);
    chk(n_clr, 1);
    chk(sample_rate_sps, 15'h0000);
    u_host.wr(8'h01, 16'h2500);
    tk(2);
    chk(sample_rate_sps, 15'h0400);
    u_host.wr(8'h01, 16'h2502);
    zc();
    u_host.refresh();
    tk(3);
    chk(n_ref, 1);
    zc();
    cv();
    tk(2);
    chk(n_ref, 1);
    chk(n_clr, 0);
    $display("test auto_refresh done");
    rs();
    @(posedge clk_sys) alert_enable <= 16'h0ff0;
    alert_cond <= 16'h3c3c;
    cv();
    u_host.rd(8'h11, d);
    chk(d, 16'h0c30);
    @(posedge clk_sys) alert_cond <= 16'h0030;
    cv();
    u_host.rd(8'h11, d);
    chk(d, 16'h0030);
    @(posedge clk_sys) alert_cond <= 16'h0c00;
    cv();
    @(posedge clk_sys) alert_cond <= 16'h0000;
    cv();
    u_host.rd(8'h11, d);
    chk(d, 16'h0c00);
    cv();
    u_host.rd(8'h11, d);
    chk(d, 16'h0000);
    $display("test alert_status done");
    tally_and_finish();
  end
endmodule // test_latched_config_and_alert_status
